/* pkg/ecl_pkg.sv */
// constants for the serial prom configuration and led status register bank
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus
// What this block does
// - bit 15 reads one on good checksum
// - checksum flag zero on failure or no prom
// - writing bit 14 starts automatic prom load
// - bus accesses stalled while loading
// - load bit self-clears; load takes 1.4 ms with a prom fitted, a few cycles without
// - bit 4 hands low bus bits to software
// - enable clear: software pin bits have no effect
// - shift busy pin follows bit 3, holds
// - bit 2 drives prom chip select
// - bit 1 drives serial shift clock
// - bit 0 writes data in, reads data out
// - bits 13 to 5 reserved, read zero
// - link register bit 15 shows link good
// - indicator_one_pin pin is OR of enabled functions
// - reset: receive activity only, stretch on
// - indicator_one_pin bit 15 shows raw combined state
// - bit 7 enables the pulse stretcher
// - bit 5 limits receive to address matches
// - polarity enable shows good receive polarity
// - bits 4,2,1,0 enable tx, rx, jabber, collision
package ecl_pkg;
    localparam logic [3:0] ECL_OFS_PROM = 4'h0;
    localparam logic [3:0] ECL_OFS_LINK = 4'h4;
    localparam logic [3:0] ECL_OFS_INDICATOR_ONE_PIN = 4'h8;
    localparam int ECL_B_VALID = 15;
    localparam int ECL_B_LOAD = 14;
    localparam int ECL_B_EN = 4;
    localparam int ECL_B_SB = 3;
    localparam int ECL_B_CS = 2;
    localparam int ECL_B_SK = 1;
    localparam int ECL_B_DATA = 0;
    localparam int ECL_B_RAW = 15;
    localparam int ECL_B_PSE = 7;
    localparam int ECL_B_MATCH = 5;
    localparam int ECL_B_TX = 4;
    localparam int ECL_B_POL = 3;
    localparam int ECL_B_RX = 2;
    localparam int ECL_B_JAB = 1;
    localparam int ECL_B_COL = 0;
    localparam logic [7:0] ECL_INDICATOR_ONE_PIN_RST = 8'h84;
    localparam logic [7:0] ECL_INDICATOR_ONE_PIN_MASK = 8'hBF;
    localparam logic [7:0] ECL_SUM_GOOD = 8'hFF;
    localparam int ECL_PROM_BYTES = 32;
    localparam int ECL_PROM_BITS = ECL_PROM_BYTES * 8;
    localparam int ECL_CLK_NS = 10;
    localparam int ECL_LOAD_NS = 1_400_000;
    localparam int ECL_LOAD_CYC = ECL_LOAD_NS / ECL_CLK_NS;
    localparam int ECL_STRETCH_NS = 50_000_000;
    localparam int ECL_STRETCH_CYC = ECL_STRETCH_NS / ECL_CLK_NS;
    localparam logic [1:0] ECL_RESP_OK = 2'b00;
    localparam logic [1:0] ECL_RESP_ERR = 2'b10;
    typedef enum logic [1:0] {
        ECL_IDLE = 2'b00,
        ECL_PROBE = 2'b01,
        ECL_SHIFT = 2'b11,
        ECL_DONE = 2'b10
    } ecl_load_t;
endpackage

/* rtl/ecl_regs.sv */
// serial prom configuration, link status and indicator_one_pin function-select registers
// assumes AXI4-Lite masters keep one write and one read in flight at most
`timescale 1ns/1ps
module ecl_regs #(
    parameter int LOAD_CYCLES = ecl_pkg::ECL_LOAD_CYC,
    parameter int STRETCH_CYCLES = ecl_pkg::ECL_STRETCH_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial prom side: bit 0 shift clock, bit 1 data in, bit 2 data out
    input wire logic [2:0] parallel_rom_data_bus_i,
    output logic [2:0] parallel_rom_data_bus_o,
    output logic [2:0] parallel_rom_data_bus_oe,
    output logic prom_chip_select,
    input wire logic shift_busy_i,
    output logic shift_busy_o,
    output logic shift_busy_oe,
    // network events
    input wire logic link_ok,
    input wire logic tx_act,
    input wire logic rx_act,
    input wire logic rx_addr_match,
    input wire logic rx_pol_good,
    input wire logic jabber,
    input wire logic collision,
    // indicators, active high
    output logic link_indicator_pin,
    output logic indicator_one_pin
);
    import ecl_pkg::*;

    localparam int HALF_CYC = LOAD_CYCLES / (2 * ECL_PROM_BITS);
    localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
    localparam logic [8:0] BIT_LAST = 9'(ECL_PROM_BITS - 1);
    localparam logic [22:0] STR_TOP = 23'(STRETCH_CYCLES);

    // bus and software register state
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic en_q, en_d, sb_q, sb_d, cs_q, cs_d, sk_q, sk_d, di_q, di_d;
    logic [7:0] led_q, led_d;
    logic start_load;
    // load engine state
    ecl_load_t st_q, st_d;
    logic [15:0] div_q, div_d;
    logic [8:0] bit_q, bit_d;
    logic [7:0] byte_q, byte_d, sum_q, sum_d;
    logic lsk_q, lsk_d, present_q, present_d, valid_q, valid_d;
    logic loading_d;
    // indicator state
    logic raw_d, raw_q, rx_ev;
    logic [22:0] str_q, str_d;
    logic indicator_one_pin_d, link_q;
    // pin registers
    logic [2:0] pb_o_d, pb_o_q, pb_oe_d, pb_oe_q;
    logic pcs_d, pcs_q, psb_d, psb_q, psb_oe_d, psb_oe_q, indicator_one_pin_q;

    logic [15:0] rd_prom, rd_link, rd_indicator_one_pin;
    logic [15:0] wmask;
    logic do_write;

    always_comb
    begin
        rd_prom = 16'h0000;
        rd_prom[ECL_B_VALID] = valid_q;
        rd_prom[ECL_B_LOAD] = (st_q != ECL_IDLE);
        rd_prom[ECL_B_EN] = en_q;
        rd_prom[ECL_B_SB] = sb_q;
        rd_prom[ECL_B_CS] = cs_q;
        rd_prom[ECL_B_SK] = sk_q;
        rd_prom[ECL_B_DATA] = parallel_rom_data_bus_i[2];
        rd_link = {link_q, 15'h0000};
        rd_indicator_one_pin = {raw_q, 7'h00, led_q};
        wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    end

    always_comb
    begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        arready_d = arready_q;
        en_d = en_q;
        sb_d = sb_q;
        cs_d = cs_q;
        sk_d = sk_q;
        di_d = di_q;
        led_d = led_q;
        start_load = 1'b0;
        do_write = aw_full_q && w_full_q && !bvalid_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = ECL_RESP_OK;
            case (awaddr_q & 4'hC)
                ECL_OFS_PROM:
                begin
                    if (wstrb_q[0])
                    begin
                        en_d = wdata_q[ECL_B_EN];
                        sb_d = wdata_q[ECL_B_SB];
                        cs_d = wdata_q[ECL_B_CS];
                        sk_d = wdata_q[ECL_B_SK];
                        di_d = wdata_q[ECL_B_DATA];
                    end
                    start_load = wstrb_q[1] && wdata_q[ECL_B_LOAD];
                end
                ECL_OFS_LINK:
                begin
                    bresp_d = ECL_RESP_OK;
                end
                ECL_OFS_INDICATOR_ONE_PIN:
                begin
                    led_d = ((led_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]))
                        & ECL_INDICATOR_ONE_PIN_MASK;
                end
                default:
                begin
                    bresp_d = ECL_RESP_ERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = ECL_RESP_OK;
            case (s_axi_araddr & 4'hC)
                ECL_OFS_PROM: rdata_d = {16'h0000, rd_prom};
                ECL_OFS_LINK: rdata_d = {16'h0000, rd_link};
                ECL_OFS_INDICATOR_ONE_PIN: rdata_d = {16'h0000, rd_indicator_one_pin};
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = ECL_RESP_ERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        // ready only while idle so a stalled load holds the master off
        awready_d = !aw_full_d && !loading_d;
        wready_d = !w_full_d && !loading_d;
        if (!rvalid_d && !loading_d)
        begin
            arready_d = 1'b1;
        end
        else
        begin
            arready_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ECL_RESP_OK;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= ECL_RESP_OK;
            rdata_q <= 32'h0000_0000;
            en_q <= 1'b0;
            sb_q <= 1'b0;
            cs_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
            led_q <= ECL_INDICATOR_ONE_PIN_RST;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            sb_q <= sb_d;
            cs_q <= cs_d;
            sk_q <= sk_d;
            di_q <= di_d;
            led_q <= led_d;
        end
    end

    // load engine: probe for a fitted prom, then clock in the image and sum it
    always_comb
    begin
        st_d = st_q;
        div_d = div_q;
        bit_d = bit_q;
        byte_d = byte_q;
        sum_d = sum_q;
        lsk_d = lsk_q;
        present_d = present_q;
        valid_d = valid_q;
        case (st_q)
            ECL_IDLE:
            begin
                if (start_load)
                begin
                    st_d = ECL_PROBE;
                end
            end
            ECL_PROBE:
            begin
                present_d = shift_busy_i;
                div_d = 16'h0000;
                bit_d = 9'h000;
                sum_d = 8'h00;
                lsk_d = 1'b0;
                st_d = shift_busy_i ? ECL_SHIFT : ECL_DONE;
            end
            ECL_SHIFT:
            begin
                div_d = div_q + 16'h0001;
                if (div_q == HALF_LAST)
                begin
                    div_d = 16'h0000;
                    lsk_d = !lsk_q;
                    if (!lsk_q)
                    begin
                        byte_d = {byte_q[6:0], parallel_rom_data_bus_i[2]};
                        if (bit_q[2:0] == 3'h7)
                        begin
                            sum_d = sum_q + {byte_q[6:0], parallel_rom_data_bus_i[2]};
                        end
                    end
                    else
                    begin
                        bit_d = bit_q + 9'h001;
                        if (bit_q == BIT_LAST)
                        begin
                            st_d = ECL_DONE;
                        end
                    end
                end
            end
            ECL_DONE:
            begin
                valid_d = present_q && (sum_q == ECL_SUM_GOOD);
                st_d = ECL_IDLE;
            end
            default:
            begin
                st_d = ECL_IDLE;
            end
        endcase
        loading_d = (st_d != ECL_IDLE);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ECL_IDLE;
            div_q <= 16'h0000;
            bit_q <= 9'h000;
            byte_q <= 8'h00;
            sum_q <= 8'h00;
            lsk_q <= 1'b0;
            present_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            sum_q <= sum_d;
            lsk_q <= lsk_d;
            present_q <= present_d;
            valid_q <= valid_d;
        end
    end

    // pin steering; with direct access off the software bits stay off the pins
    always_comb
    begin
        pb_o_d = 3'b000;
        pb_oe_d = 3'b000;
        pcs_d = 1'b0;
        // with direct access off the pin keeps its last programmed level
        psb_d = en_q ? sb_q : psb_q;
        psb_oe_d = 1'b1;
        if (st_q == ECL_PROBE || st_d == ECL_PROBE)
        begin
            psb_oe_d = 1'b0;
        end
        else if (st_q == ECL_SHIFT)
        begin
            pb_o_d = {1'b0, 1'b0, lsk_q};
            pb_oe_d = 3'b011;
            pcs_d = 1'b1;
        end
        else if (en_q)
        begin
            pb_o_d = {1'b0, di_q, sk_q};
            pb_oe_d = 3'b011;
            pcs_d = cs_q;
        end
        else
        begin
            pb_oe_d = 3'b000;
        end
    end

    // indicators; raw combined state and stretcher
    assign rx_ev = rx_act && (!led_q[ECL_B_MATCH] || rx_addr_match);
    always_comb
    begin
        raw_d = (tx_act && led_q[ECL_B_TX]) || (rx_ev && led_q[ECL_B_RX])
            || (jabber && led_q[ECL_B_JAB]) || (collision && led_q[ECL_B_COL])
            || (rx_pol_good && led_q[ECL_B_POL]);
        str_d = str_q;
        if (raw_q)
        begin
            str_d = STR_TOP;
        end
        else if (str_q != 23'h00_0000)
        begin
            str_d = str_q - 23'h00_0001;
        end
        indicator_one_pin_d = raw_q || (led_q[ECL_B_PSE] && str_q != 23'h00_0000);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            raw_q <= 1'b0;
            str_q <= 23'h00_0000;
            indicator_one_pin_q <= 1'b0;
            link_q <= 1'b0;
            pb_o_q <= 3'b000;
            pb_oe_q <= 3'b000;
            pcs_q <= 1'b0;
            psb_q <= 1'b0;
            psb_oe_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw_d;
            str_q <= str_d;
            indicator_one_pin_q <= indicator_one_pin_d;
            link_q <= link_ok;
            pb_o_q <= pb_o_d;
            pb_oe_q <= pb_oe_d;
            pcs_q <= pcs_d;
            psb_q <= psb_d;
            psb_oe_q <= psb_oe_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign parallel_rom_data_bus_o = pb_o_q;
    assign parallel_rom_data_bus_oe = pb_oe_q;
    assign prom_chip_select = pcs_q;
    assign shift_busy_o = psb_q;
    assign shift_busy_oe = psb_oe_q;
    assign link_indicator_pin = link_q;
    assign indicator_one_pin = indicator_one_pin_q;

    a_stall_in_load: assert property (@(posedge clk) disable iff (rst)
        (st_q == ECL_SHIFT) |-> (!s_axi_awready && !s_axi_arready && !s_axi_wready))
        else $error("bus accepted during load");
    a_absent_prom: assert property (@(posedge clk) disable iff (rst)
        (st_q == ECL_PROBE && !shift_busy_i) |=> ##1 !valid_q)
        else $error("valid set without prom");
    a_sum_checked: assert property (@(posedge clk) disable iff (rst)
        (st_q == ECL_DONE) |=> (valid_q == ($past(present_q) && $past(sum_q) == 8'hFF)))
        else $error("checksum flag wrong");
    a_load_ends: assert property (@(posedge clk) disable iff (rst)
        (st_q == ECL_DONE) |=> (st_q == ECL_IDLE))
        else $error("load bit not cleared");
    a_pins_quiet: assert property (@(posedge clk) disable iff (rst)
        (!en_q && st_q == ECL_IDLE && $past(st_q) == ECL_IDLE && !$past(en_q))
        |-> (parallel_rom_data_bus_oe == 3'b000 && !prom_chip_select))
        else $error("pins driven without enable");
    a_direct_clock: assert property (@(posedge clk) disable iff (rst)
        (en_q && st_q == ECL_IDLE) |=> (parallel_rom_data_bus_o[0] == $past(sk_q)
        && prom_chip_select == $past(cs_q)))
        else $error("direct pins do not follow bits");
    a_no_enable_dark: assert property (@(posedge clk) disable iff (rst)
        (led_q[4:0] == 5'h00) |=> !raw_q)
        else $error("raw state set with no enables");
    a_stretch_hold: assert property (@(posedge clk) disable iff (rst)
        ($fell(raw_q) && led_q[ECL_B_PSE]) |-> ##1 indicator_one_pin [*2])
        else $error("stretch did not extend");
    a_link_follow: assert property (@(posedge clk) disable iff (rst)
        link_indicator_pin == $past(link_ok))
        else $error("link pin wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (s_axi_rvalid && s_axi_rresp == ECL_RESP_OK) |-> (s_axi_rdata[31:16] == 16'h0000))
        else $error("upper bits not zero");
    c_load_done: cover property (@(posedge clk) disable iff (rst) st_q == ECL_DONE);
    c_direct_write: cover property (@(posedge clk) disable iff (rst) en_q && sk_q);
    c_stretch: cover property (@(posedge clk) disable iff (rst) !raw_q && indicator_one_pin);
    c_unmapped: cover property (@(posedge clk) disable iff (rst)
        s_axi_rvalid && s_axi_rresp == ECL_RESP_ERR);
endmodule

/* sim/ecl_prom_model.sv */
// behavioural serial prom: 32 byte image, msb first, bytes summing to ff
// assumes the block samples data out on the rising shift clock
`timescale 1ns/1ps
module ecl_prom_model (
    // serial side
    input wire logic cs,
    input wire logic sk,
    output logic do_o,
    // fitting options
    input wire logic present,
    input wire logic corrupt,
    output logic busy_lvl
);
    logic [7:0] img [32];
    logic [7:0] sum;
    int idx;
    logic bit_now;
    initial
    begin
        sum = 8'h00;
        for (int i = 0; i < 31; i++)
        begin
            img[i] = 8'(i * 7);
            sum = sum + img[i];
        end
        img[31] = 8'hFF - sum;
        idx = 0;
    end
    // a missing prom leaves the busy line on its pull-down
    assign busy_lvl = present;
    always @(posedge cs) idx = 0;
    always @(negedge sk) if (cs && idx < 255) idx = idx + 1;
    assign bit_now = img[idx / 8][7 - (idx % 8)] ^ (corrupt && idx == 0);
    // a released data out line falls to the board pull-down
    assign do_o = (cs && present) ? bit_now : 1'b0;
endmodule

/* sim/tb_eeprom_config_and_led_status_regs.sv */
// self-checking bench for the prom config and led status registers
// assumes the register block with short load and stretch counts
`timescale 1ns/1ps
module tb_eeprom_config_and_led_status_regs;
    import ecl_pkg::*;
    localparam int LIM = 5000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [2:0] parallel_rom_data_bus_i;
    logic [2:0] parallel_rom_data_bus_o;
    logic [2:0] parallel_rom_data_bus_oe;
    logic prom_chip_select;
    logic shift_busy_i;
    logic shift_busy_o;
    logic shift_busy_oe;
    logic link_ok = 1'b0;
    logic [4:0] ev = 5'h00;
    logic rx_addr_match = 1'b0;
    logic link_indicator_pin;
    logic indicator_one_pin;
    logic prom_present = 1'b0;
    logic prom_bad = 1'b0;
    logic prom_do;
    logic busy_lvl;
    int err_total = 0;
    int n_checks = 0;

    always #5 clk = ~clk;
    // undriven bus lines sit on pull-downs
    assign parallel_rom_data_bus_i = {prom_do, parallel_rom_data_bus_oe[1:0]
        & parallel_rom_data_bus_o[1:0]};
    assign shift_busy_i = shift_busy_oe ? shift_busy_o : busy_lvl;

    ecl_regs #(.LOAD_CYCLES(1024), .STRETCH_CYCLES(8)) u_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .parallel_rom_data_bus_i,
        .parallel_rom_data_bus_o, .parallel_rom_data_bus_oe, .prom_chip_select,
        .shift_busy_i, .shift_busy_o, .shift_busy_oe, .link_ok, .tx_act(ev[4]),
        .rx_act(ev[2]), .rx_addr_match, .rx_pol_good(ev[3]), .jabber(ev[1]),
        .collision(ev[0]), .link_indicator_pin, .indicator_one_pin);

    ecl_prom_model u_prom (.cs(prom_chip_select), .sk(parallel_rom_data_bus_i[0]),
        .do_o(prom_do), .present(prom_present), .corrupt(prom_bad),
        .busy_lvl(busy_lvl));

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask

    task automatic tmo(input int n);
        if (n >= LIM)
        begin
            err_total++;
            conclude();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < LIM && !(ad && wd); n++)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        tmo(n);
        for (n = 0; n < LIM && s_axi_bvalid !== 1'b1; n++) @(posedge clk);
        tmo(n);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < LIM; n++)
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        tmo(n);
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset();
        rd(ECL_OFS_PROM, 32'h0000_0000, ECL_RESP_OK);
        rd(ECL_OFS_INDICATOR_ONE_PIN, 32'(ECL_INDICATOR_ONE_PIN_RST), ECL_RESP_OK);
        rd(4'hC, 32'h0000_0000, ECL_RESP_ERR);
        wr(4'hC, 32'h0000_FFFF, ECL_RESP_ERR);
    endtask

    task automatic t_load(input logic p, input logic c, input logic [31:0] exp);
        prom_present <= p;
        prom_bad <= c;
        @(posedge clk);
        wr(ECL_OFS_PROM, 32'h0000_4000, ECL_RESP_OK);
        cyc(20);
        chkb(prom_chip_select, p);
        // the read stalls until the load has finished
        rd(ECL_OFS_PROM, exp, ECL_RESP_OK);
    endtask

    task automatic t_direct();
        prom_bad <= 1'b1;
        wr(ECL_OFS_PROM, 32'h0000_001F, ECL_RESP_OK);
        chk(32'({parallel_rom_data_bus_oe[1:0], parallel_rom_data_bus_o[1:0],
            prom_chip_select, shift_busy_oe, shift_busy_o}), 32'h0000_007F);
        rd(ECL_OFS_PROM, 32'h0000_801F, ECL_RESP_OK);
        wr(ECL_OFS_PROM, 32'h0000_0000, ECL_RESP_OK);
        chk(32'({parallel_rom_data_bus_oe, parallel_rom_data_bus_o,
            prom_chip_select, shift_busy_oe, shift_busy_o}), 32'h0000_0003);
        wr(ECL_OFS_PROM, 32'h0000_0010, ECL_RESP_OK);
        chkb(shift_busy_o, 1'b0);
        wr(ECL_OFS_PROM, 32'h0000_0000, ECL_RESP_OK);
        rd(ECL_OFS_PROM, 32'h0000_8000, ECL_RESP_OK);
    endtask

    task automatic t_led();
        for (int b = 0; b < 5; b++)
        begin
            wr(ECL_OFS_INDICATOR_ONE_PIN, 32'(1 << b), ECL_RESP_OK);
            ev <= ~(5'h01 << b);
            cyc(3);
            chkb(indicator_one_pin, 1'b0);
            ev <= 5'h01 << b;
            cyc(3);
            chkb(indicator_one_pin, 1'b1);
            rd(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_8000 | 32'(1 << b), ECL_RESP_OK);
            ev <= 5'h00;
            cyc(3);
            chkb(indicator_one_pin, 1'b0);
        end
        wr(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_0000, ECL_RESP_OK);
        ev <= 5'h1F;
        cyc(3);
        chkb(indicator_one_pin, 1'b0);
        wr(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_0024, ECL_RESP_OK);
        ev <= 5'h04;
        cyc(3);
        chkb(indicator_one_pin, 1'b0);
        rx_addr_match <= 1'b1;
        cyc(3);
        chkb(indicator_one_pin, 1'b1);
        ev <= 5'h00;
        rx_addr_match <= 1'b0;
        wr(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_FFFF, ECL_RESP_OK);
        rd(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_00BF, ECL_RESP_OK);
        wr(ECL_OFS_INDICATOR_ONE_PIN, 32'h0000_0084, ECL_RESP_OK);
        ev <= 5'h04;
        @(posedge clk);
        ev <= 5'h00;
        cyc(6);
        chkb(indicator_one_pin, 1'b1);
        ev <= 5'h04;
        @(posedge clk);
        ev <= 5'h00;
        cyc(6);
        chkb(indicator_one_pin, 1'b1);
        cyc(20);
        chkb(indicator_one_pin, 1'b0);
    endtask

    task automatic t_link();
        link_ok <= 1'b1;
        cyc(3);
        chkb(link_indicator_pin, 1'b1);
        rd(ECL_OFS_LINK, 32'h0000_8000, ECL_RESP_OK);
        wr(ECL_OFS_LINK, 32'h0000_FFFF, ECL_RESP_OK);
        link_ok <= 1'b0;
        cyc(3);
        rd(ECL_OFS_LINK, 32'h0000_0000, ECL_RESP_OK);
    endtask

    // a hang anywhere ends here instead of running forever
    initial
    begin
        #900_000;
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_load(1'b0, 1'b0, 32'h0000_0000);
        t_load(1'b1, 1'b1, 32'h0000_0000);
        t_load(1'b1, 1'b0, 32'h0000_8000);
        t_direct();
        t_led();
        t_link();
        conclude();
    end
endmodule
